// ### common/cbam_pkg.sv
/*
  shared constants for the central-arbitration bus module side: tenure
  states, competition number layout, message code ranges and profiles.
  assumes a single clock domain and nothing else of its surroundings.
*/
package cbam_pkg;

  typedef enum logic [2:0] {
    CBAM_IDLE   = 3'b000,
    CBAM_REQ    = 3'b001,
    CBAM_ELECT  = 3'b010,
    CBAM_OWN    = 3'b011,
    CBAM_TENURE = 3'b100,
    CBAM_LAST   = 3'b101
  } cbam_state_e;

  typedef enum logic [1:0] {
    CBAM_TX_IDLE  = 2'b00,
    CBAM_TX_PASS1 = 2'b01,
    CBAM_TX_PASS2 = 2'b10
  } cbam_tx_e;

  // profile strap encodings
  localparam logic [1:0] PROF_A = 2'h0;
  localparam logic [1:0] PROF_B = 2'h1;
  localparam logic [1:0] PROF_F = 2'h2;

  // competition number layout
  localparam int         CN_W        = 8;
  localparam int         CODE_W      = 7;
  localparam int         SLOT_W      = 5;
  localparam int         CN_MSG_BIT  = 7;
  localparam int         CN_LINE_BIT = 5;
  localparam int         MSG_CODES   = 128;
  localparam logic [7:0] CN_ALL_ONES = 8'hFF;

  // message code ranges
  localparam logic [6:0] PF_LO  = 7'h60;
  localparam logic [6:0] PF_HI  = 7'h7F;
  localparam logic [6:0] OPT_HI = 7'h5F;
  // backplane delay code: value is arbitrary, set per system
  localparam logic [6:0] BP_DELAY_CODE = 7'h10;

  // synchronised pin count and reset values
  localparam int         SYNC_W      = 12;
  localparam logic [7:0] AB_IDLE     = 8'hFF;

endpackage : cbam_pkg

// ### hw/cbam_sync.sv
/*
  two flip-flop synchroniser for a vector of pin inputs.
  assumes inputs idle high (active-low backplane lines).
*/
module cbam_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;

endmodule : cbam_sync

// ### hw/cbam_codec.sv
/*
  message encoder and decoder for the arbitration number lines.
  purely combinational; assumes the caller registers its outputs.
*/
module cbam_codec (
  input  wire logic       central_mode,
  input  wire logic       msg_central,
  input  wire logic [6:0] msg_code,
  input  wire logic [6:0] msg_prio,
  input  wire logic [4:0] msg_slot,
  input  wire logic       msg_line,
  input  wire logic [6:0] rx_code,
  output logic      [7:0] pass1,
  output logic      [7:0] pass2,
  output logic            two_pass,
  output logic            is_power_fail,
  output logic            is_bp_delay
);

  always_comb begin
    pass1    = {1'b1, msg_code};
    pass2    = cbam_pkg::CN_ALL_ONES;
    two_pass = 1'b0;
    if (!central_mode) begin
      pass1    = cbam_pkg::CN_ALL_ONES;
      pass2    = {1'b1, msg_code};
      two_pass = 1'b1;
    end else if (msg_central) begin
      pass1    = {1'b0, msg_prio};
      pass2    = 8'h00;
      pass2[cbam_pkg::SLOT_W-1:0]   = msg_slot;
      pass2[cbam_pkg::CN_LINE_BIT]  = msg_line;
      two_pass = 1'b1;
    end
  end

  assign is_power_fail = (rx_code >= cbam_pkg::PF_LO) &&
                         (rx_code <= cbam_pkg::PF_HI);
  assign is_bp_delay   = (rx_code == cbam_pkg::BP_DELAY_CODE);

endmodule : cbam_codec

// ### hw/cbam_host.sv
/*
  bus module side of central arbitration: drives the two request lines,
  follows grant and preempt, drives end-of-tenure, sends and receives
  arbitration messages on the eight arbitration number lines.
  assumes a central arbiter on gr_n/pe_n, wired-or et_n and ab_n lines
  resolved outside, and an external competition strobe cmp_n whose
  rising edge marks the end of a competition pass.
*/
// Operation
// - request on either line; rq1 ranks higher
// - hold request until final transfer as master
// - release both request lines in one cycle
// - start transfers only after et released
// - assert et after beginning transaction, hold
// - release bus signals, then release et
// - 128 seven-bit message codes on eight lines
// - distributed: all-ones pass, then coded pass
// - central general message: one pass, bit7 set
// - central message: priority then slot, line
// - profile b: central at power-up, ranges
// - profile f: central only, pf, delay message
module cbam_host (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  output logic            rq0_n,
  output logic            rq1_n,
  input  wire logic       gr_n,
  input  wire logic       pe_n,
  input  wire logic       et_n_i,
  output logic            et_n_o,
  output logic            et_n_oe_n,
  input  wire logic [7:0] ab_n_i,
  output logic      [7:0] ab_n_o,
  output logic      [7:0] ab_n_oe_n,
  input  wire logic       cmp_n,
  input  wire logic [1:0] profile_sel,
  input  wire logic       dist_pref,
  input  wire logic       monarch_cap,
  input  wire logic       ten_req,
  input  wire logic [1:0] ten_level,
  input  wire logic       ten_first,
  input  wire logic       ten_last,
  input  wire logic       ten_done,
  output logic            master_elect,
  output logic            bus_owner,
  output logic            preempted,
  input  wire logic       msg_go,
  input  wire logic       msg_central,
  input  wire logic [6:0] msg_code,
  input  wire logic [6:0] msg_prio,
  input  wire logic [4:0] msg_slot,
  input  wire logic       msg_line,
  output logic            msg_busy,
  output logic            central_mode,
  output logic            rx_valid,
  output logic      [7:0] rx_cn,
  output logic      [6:0] rx_code,
  output logic            rx_power_fail,
  output logic            rx_bp_delay
);

  // reset release
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // pin inputs
  logic [cbam_pkg::SYNC_W-1:0] pins_s;
  logic       gr_s;
  logic       pe_s;
  logic       et_s;
  logic       cmp_s;
  logic [7:0] ab_s;

  cbam_sync #(
    .W (cbam_pkg::SYNC_W)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     ({cmp_n, gr_n, pe_n, et_n_i, ab_n_i}),
    .dout    (pins_s)
  );

  assign ab_s  = pins_s[7:0];
  assign et_s  = pins_s[8];
  assign pe_s  = pins_s[9];
  assign gr_s  = pins_s[10];
  assign cmp_s = pins_s[11];

  // profile strap, taken once after reset release
  logic strap_done_r;
  logic strap_done_nxt;
  logic central_r;
  logic central_nxt;

  always_comb begin
    strap_done_nxt = 1'b1;
    central_nxt    = central_r;
    if (!strap_done_r) begin
      case (profile_sel)
        cbam_pkg::PROF_B: central_nxt = 1'b1;
        cbam_pkg::PROF_F: central_nxt = 1'b1;
        default:          central_nxt = !dist_pref;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_r <= 1'b0;
      central_r    <= 1'b1;
    end else begin
      strap_done_r <= strap_done_nxt;
      central_r    <= central_nxt;
    end
  end

  assign central_mode = central_r;

  // tenure sequence
  cbam_pkg::cbam_state_e st_r;
  cbam_pkg::cbam_state_e st_nxt;
  logic [1:0] rq_r;
  logic [1:0] rq_nxt;
  logic       et_r;
  logic       et_nxt;
  logic [1:0] level;

  // an empty level still needs a line: fall back to the low one
  assign level = (ten_level == 2'b00) ? 2'b01 : ten_level;

  always_comb begin
    st_nxt = st_r;
    rq_nxt = rq_r;
    et_nxt = et_r;
    case (st_r)
      cbam_pkg::CBAM_IDLE: begin
        if (ten_req && central_r) begin
          rq_nxt = level;
          st_nxt = cbam_pkg::CBAM_REQ;
        end
      end
      cbam_pkg::CBAM_REQ: begin
        if (!ten_req) begin
          rq_nxt = 2'b00;
          st_nxt = cbam_pkg::CBAM_IDLE;
        end else if (!gr_s) begin
          st_nxt = cbam_pkg::CBAM_ELECT;
        end
      end
      cbam_pkg::CBAM_ELECT: begin
        if (!ten_req) begin
          rq_nxt = 2'b00;
          st_nxt = cbam_pkg::CBAM_IDLE;
        end else if (et_s) begin
          st_nxt = cbam_pkg::CBAM_OWN;
        end
      end
      cbam_pkg::CBAM_OWN: begin
        if (ten_first) begin
          et_nxt = 1'b1;
        end
        if (ten_last) begin
          rq_nxt = 2'b00;
          st_nxt = cbam_pkg::CBAM_LAST;
        end else if (ten_first) begin
          st_nxt = cbam_pkg::CBAM_TENURE;
        end
      end
      cbam_pkg::CBAM_TENURE: begin
        if (ten_last) begin
          rq_nxt = 2'b00;
          st_nxt = cbam_pkg::CBAM_LAST;
        end
      end
      cbam_pkg::CBAM_LAST: begin
        if (ten_first) begin
          et_nxt = 1'b1;
        end
        if (ten_done) begin
          et_nxt = 1'b0;
          st_nxt = cbam_pkg::CBAM_IDLE;
        end
      end
      default: begin
        rq_nxt = 2'b00;
        et_nxt = 1'b0;
        st_nxt = cbam_pkg::CBAM_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= cbam_pkg::CBAM_IDLE;
      rq_r <= 2'b00;
      et_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      rq_r <= rq_nxt;
      et_r <= et_nxt;
    end
  end

  assign rq0_n     = !rq_r[0];
  assign rq1_n     = !rq_r[1];
  assign et_n_o    = 1'b0;
  assign et_n_oe_n = !et_r;

  assign master_elect = (st_r == cbam_pkg::CBAM_ELECT);
  assign bus_owner    = (st_r == cbam_pkg::CBAM_OWN) ||
                        (st_r == cbam_pkg::CBAM_TENURE);
  // preempt is only meaningful while this module holds the grant
  assign preempted    = !pe_s && !gr_s && (rq_r != 2'b00);

  // competition strobe edge and capture
  logic cmp_d_r;
  logic cmp_edge;
  logic [7:0] cap_r;
  logic [7:0] cap_nxt;
  logic       prev_ones_r;
  logic       prev_ones_nxt;
  logic       rx_v_r;
  logic       rx_v_nxt;
  logic [6:0] rxc_r;
  logic [6:0] rxc_nxt;
  logic       pf_r;
  logic       pf_nxt;
  logic       bp_r;
  logic       bp_nxt;
  logic [7:0] cn_now;
  logic       dec_pf;
  logic       dec_bp;

  assign cmp_edge = cmp_s && !cmp_d_r;
  assign cn_now   = ~ab_s;

  // message encoder and decoder
  logic [7:0] pass1;
  logic [7:0] pass2;
  logic       two_pass;

  cbam_codec u_codec (
    .central_mode  (central_r),
    .msg_central   (msg_central),
    .msg_code      (msg_code),
    .msg_prio      (msg_prio),
    .msg_slot      (msg_slot),
    .msg_line      (msg_line),
    .rx_code       (cn_now[cbam_pkg::CODE_W-1:0]),
    .pass1         (pass1),
    .pass2         (pass2),
    .two_pass      (two_pass),
    .is_power_fail (dec_pf),
    .is_bp_delay   (dec_bp)
  );

  always_comb begin
    cap_nxt       = cap_r;
    prev_ones_nxt = prev_ones_r;
    rx_v_nxt      = 1'b0;
    rxc_nxt       = rxc_r;
    pf_nxt        = pf_r;
    bp_nxt        = bp_r;
    if (cmp_edge) begin
      cap_nxt       = cn_now;
      prev_ones_nxt = (cn_now == cbam_pkg::CN_ALL_ONES);
      // a message is delivered here and never touches tenure state
      if (cn_now[cbam_pkg::CN_MSG_BIT] &&
          (central_r || prev_ones_r) &&
          (cn_now != cbam_pkg::CN_ALL_ONES || prev_ones_r)) begin
        rx_v_nxt = 1'b1;
        // a delivered all-ones code must not open the next message
        prev_ones_nxt = 1'b0;
        rxc_nxt  = cn_now[cbam_pkg::CODE_W-1:0];
        pf_nxt   = dec_pf;
        bp_nxt   = dec_bp && monarch_cap;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmp_d_r     <= 1'b1;
      cap_r       <= 8'h00;
      prev_ones_r <= 1'b0;
      rx_v_r      <= 1'b0;
      rxc_r       <= 7'h00;
      pf_r        <= 1'b0;
      bp_r        <= 1'b0;
    end else begin
      cmp_d_r     <= cmp_s;
      cap_r       <= cap_nxt;
      prev_ones_r <= prev_ones_nxt;
      rx_v_r      <= rx_v_nxt;
      rxc_r       <= rxc_nxt;
      pf_r        <= pf_nxt;
      bp_r        <= bp_nxt;
    end
  end

  assign rx_cn         = cap_r;
  assign rx_valid      = rx_v_r;
  assign rx_code       = rxc_r;
  assign rx_power_fail = pf_r;
  assign rx_bp_delay   = bp_r;

  // message transmit: each pass held until a competition ends
  cbam_pkg::cbam_tx_e tx_r;
  cbam_pkg::cbam_tx_e tx_nxt;
  logic [7:0] p2_r;
  logic [7:0] p2_nxt;
  logic [7:0] drv_r;
  logic [7:0] drv_nxt;
  logic       two_r;
  logic       two_nxt;

  always_comb begin
    tx_nxt  = tx_r;
    p2_nxt  = p2_r;
    drv_nxt = drv_r;
    two_nxt = two_r;
    case (tx_r)
      cbam_pkg::CBAM_TX_IDLE: begin
        if (msg_go) begin
          drv_nxt = pass1;
          p2_nxt  = pass2;
          two_nxt = two_pass;
          tx_nxt  = cbam_pkg::CBAM_TX_PASS1;
        end
      end
      cbam_pkg::CBAM_TX_PASS1: begin
        if (cmp_edge) begin
          if (two_r) begin
            drv_nxt = p2_r;
            tx_nxt  = cbam_pkg::CBAM_TX_PASS2;
          end else begin
            drv_nxt = 8'h00;
            tx_nxt  = cbam_pkg::CBAM_TX_IDLE;
          end
        end
      end
      cbam_pkg::CBAM_TX_PASS2: begin
        if (cmp_edge) begin
          drv_nxt = 8'h00;
          tx_nxt  = cbam_pkg::CBAM_TX_IDLE;
        end
      end
      default: begin
        drv_nxt = 8'h00;
        tx_nxt  = cbam_pkg::CBAM_TX_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_r  <= cbam_pkg::CBAM_TX_IDLE;
      p2_r  <= 8'h00;
      drv_r <= 8'h00;
      two_r <= 1'b0;
    end else begin
      tx_r  <= tx_nxt;
      p2_r  <= p2_nxt;
      drv_r <= drv_nxt;
      two_r <= two_nxt;
    end
  end

  // wired-or lines: a one in the number pulls its line low
  assign ab_n_o    = 8'h00;
  assign ab_n_oe_n = ~drv_r;
  assign msg_busy  = (tx_r != cbam_pkg::CBAM_TX_IDLE);

endmodule : cbam_host

// ### dv/cbam_host_asserts.sv
/*
  port checker for cbam_host, bound onto every instance.
  assumes one clock domain and the 2-flop pin synchronisers.
*/
module cbam_host_asserts (
  input wire logic       clk_sys,
  input wire logic       nrst,
  input wire logic       rq0_n,
  input wire logic       rq1_n,
  input wire logic       gr_n,
  input wire logic       et_n_i,
  input wire logic       et_n_oe_n,
  input wire logic [7:0] ab_n_oe_n,
  input wire logic       monarch_cap,
  input wire logic       ten_req,
  input wire logic [1:0] ten_level,
  input wire logic       ten_first,
  input wire logic       ten_done,
  input wire logic       master_elect,
  input wire logic       bus_owner,
  input wire logic       msg_go,
  input wire logic       msg_central,
  input wire logic [6:0] msg_code,
  input wire logic [6:0] msg_prio,
  input wire logic       msg_busy,
  input wire logic       central_mode,
  input wire logic       rx_valid,
  input wire logic [7:0] rx_cn,
  input wire logic [6:0] rx_code,
  input wire logic       rx_power_fail,
  input wire logic       rx_bp_delay
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_both_rel;
    !rq0_n && !rq1_n ##1 (rq0_n || rq1_n);
  endsequence
  sequence s_msg_take;
    msg_go && !msg_busy;
  endsequence

  property p_pair; s_both_rel |-> rq0_n && rq1_n; endproperty
  property p_hold; master_elect || bus_owner |-> !rq0_n || !rq1_n;
  endproperty
  property p_rq1;
    $fell(rq1_n) |-> $past(ten_req) && $past(ten_level[1]);
  endproperty
  property p_elect; $rose(master_elect) |-> !$past(gr_n, 3); endproperty
  property p_own; $rose(bus_owner) |-> $past(et_n_i, 3); endproperty
  property p_et_on;
    $fell(et_n_oe_n) |-> $past(ten_first) &&
      ($past(bus_owner) || (rq0_n && rq1_n));
  endproperty
  property p_et_off;
    $rose(et_n_oe_n) |-> $past(ten_done) && rq0_n && rq1_n;
  endproperty
  property p_pass1;
    s_msg_take |=> ab_n_oe_n == ~(!central_mode ? 8'hFF :
      $past(msg_central) ? {1'b0, $past(msg_prio)} :
      {1'b1, $past(msg_code)});
  endproperty
  property p_rx; rx_valid |-> rx_cn[7] && rx_code == rx_cn[6:0];
  endproperty
  property p_pf;
    rx_valid |-> rx_power_fail == (rx_code >= cbam_pkg::PF_LO) &&
      rx_bp_delay == (rx_code == cbam_pkg::BP_DELAY_CODE && monarch_cap);
  endproperty

  a_pair: assert property (p_pair)
    else $error("request lines released apart");
  a_hold: assert property (p_hold)
    else $error("request dropped before final transfer");
  a_rq1: assert property (p_rq1)
    else $error("high request line without a request");
  a_elect: assert property (p_elect)
    else $error("master elect without grant");
  a_own: assert property (p_own)
    else $error("ownership taken while tenure line held");
  a_et_on: assert property (p_et_on)
    else $error("tenure line asserted without a transaction");
  a_et_off: assert property (p_et_off)
    else $error("tenure line released early");
  a_pass1: assert property (p_pass1)
    else $error("first pass number wrong");
  a_rx: assert property (p_rx)
    else $error("received code does not match number");
  a_pf: assert property (p_pf)
    else $error("message class flags wrong");
endmodule : cbam_host_asserts

bind cbam_host cbam_host_asserts u_chk (.clk_sys, .nrst, .rq0_n, .rq1_n,
  .gr_n, .et_n_i, .et_n_oe_n, .ab_n_oe_n, .monarch_cap, .ten_req,
  .ten_level, .ten_first, .ten_done, .master_elect, .bus_owner, .msg_go,
  .msg_central, .msg_code, .msg_prio, .msg_busy, .central_mode,
  .rx_valid, .rx_cn, .rx_code, .rx_power_fail, .rx_bp_delay);

// ### dv/cbam_arb.sv
/*
  central arbiter model for two modules: the one under test (two request
  lines) and a rival on one high line. assumes active-low pins.
*/
module cbam_arb (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic rq0_n,
  input  wire logic rq1_n,
  input  wire logic rv_rq_n,
  input  wire logic slow,
  output logic      gr_n,
  output logic      rv_gr_n,
  output logic      pe_n
);
  logic [1:0] own_r, own_nxt, pick, ld, lr;
  logic       last_r, last_nxt;
  logic [2:0] dly_r, dly_nxt;

  assign ld = !rq1_n ? 2'h2 : {1'b0, !rq0_n};
  assign lr = rv_rq_n ? 2'h0 : 2'h2;
  // tie goes to whoever was not granted last
  assign pick = (ld == 2'h0 && lr == 2'h0) ? 2'h0 :
                (ld > lr || (ld == lr && !last_r)) ? 2'h1 : 2'h2;

  always_comb begin
    own_nxt  = own_r;
    last_nxt = last_r;
    dly_nxt  = (own_r != 2'h0) ? (slow ? 3'h5 : 3'h0) : dly_r;
    if (own_r == 2'h0 || (own_r == 2'h1 && ld == 2'h0) ||
        (own_r == 2'h2 && lr == 2'h0)) begin
      own_nxt = 2'h0;
      if (pick != 2'h0 && (dly_r == 3'h0 || own_r != 2'h0)) begin
        own_nxt  = pick;
        last_nxt = (pick == 2'h1);
      end else if (dly_r != 3'h0) begin
        dly_nxt = dly_r - 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      own_r  <= 2'h0;
      last_r <= 1'b0;
      dly_r  <= 3'h0;
    end else begin
      own_r  <= own_nxt;
      last_r <= last_nxt;
      dly_r  <= dly_nxt;
    end
  end

  assign gr_n    = !(own_r == 2'h1);
  assign rv_gr_n = !(own_r == 2'h2);
  // falls when the other module's request outranks the owner's; derived from the owner and both request levels
  assign pe_n = !((own_r == 2'h1 && lr > ld) ||
                  (own_r == 2'h2 && ld > lr));
endmodule : cbam_arb

// ### dv/tb.sv
/*
  bench for cbam_host: arbiter model, a rival module driven here, and
  messages looped back over the wired lines. assumes the bound checker.
*/
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic       clk_sys = 1'b0, nrst = 1'b0, cmp_n = 1'b1, slow = 1'b0;
  logic       rq0_n, rq1_n, gr_n, pe_n, et_n_o, et_n_oe_n, rv_gr_n;
  logic       rv_rq_n = 1'b1, rv_et_n = 1'b1, dist_pref = 1'b0;
  logic [7:0] ab_n_o, ab_n_oe_n, rx_cn, rv_ab_n = 8'hFF;
  logic [1:0] profile_sel = 2'h1, ten_level = 2'h3;
  logic       monarch_cap = 1'b1, ten_req = 1'b0, ten_first = 1'b0;
  logic       ten_last = 1'b0, ten_done = 1'b0, msg_go = 1'b0;
  logic       msg_central = 1'b0, msg_line = 1'b0;
  logic [6:0] msg_code = 7'h00, msg_prio = 7'h00, rx_code;
  logic [4:0] msg_slot = 5'h00;
  logic       master_elect, bus_owner, preempted, msg_busy, central_mode;
  logic       rx_valid, rx_power_fail, rx_bp_delay;
  logic [9:0] exp_q[$];
  int         miscompares = 0, tests_run = 0;
  // released lines float high through the backplane pull-ups
  wire logic       et_w = (et_n_oe_n | et_n_o) & rv_et_n;
  wire logic [7:0] ab_w = (ab_n_oe_n | ab_n_o) & rv_ab_n;

  always #2 clk_sys = ~clk_sys;

  cbam_host dut (.clk_sys, .nrst, .rq0_n, .rq1_n, .gr_n, .pe_n,
    .et_n_i(et_w), .et_n_o, .et_n_oe_n, .ab_n_i(ab_w), .ab_n_o,
    .ab_n_oe_n, .cmp_n, .profile_sel, .dist_pref, .monarch_cap, .ten_req,
    .ten_level, .ten_first, .ten_last, .ten_done, .master_elect,
    .bus_owner, .preempted, .msg_go, .msg_central, .msg_code, .msg_prio,
    .msg_slot, .msg_line, .msg_busy, .central_mode, .rx_valid, .rx_cn,
    .rx_code, .rx_power_fail, .rx_bp_delay);
  cbam_arb u_arb (.clk_sys, .rst_n(nrst), .rq0_n, .rq1_n, .rv_rq_n,
    .slow, .gr_n, .rv_gr_n, .pe_n);

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [9:0] e, g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cyc

  task automatic waitv(ref logic s, input logic v, input string nm);
    for (int i = 0; i < 200 && s !== v; i++) cyc(1);
    if (s !== v) begin
      chk(nm, {9'h0, v}, {9'h0, s});
      tally_and_finish();
    end
  endtask : waitv

  task automatic do_reset(input logic [1:0] p, input logic d);
    nrst = 1'b0;
    profile_sel = p;
    dist_pref = d;
    cyc(4);
    nrst = 1'b1;
    cyc(6);
  endtask : do_reset

  task automatic comp_pass();
    cyc(3);
    cmp_n = 1'b0;
    cyc(2);
    cmp_n = 1'b1;
    cyc(6);
  endtask : comp_pass

  task automatic tenure(input logic [1:0] lv);
    ten_level = lv;
    slow = 1'($urandom);
    rv_et_n = 1'b0;
    // the request is a level: it must stand until the final transfer
    ten_req = 1'b1;
    waitv(master_elect, 1'b1, "elect");
    chk("rq", {8'h0, ~lv}, {8'h0, rq1_n, rq0_n});
    rv_rq_n = 1'b0;
    cyc(4);
    chk("owner early", 10'h0, {9'h0, bus_owner});
    chk("preempt", {9'h0, lv == 2'h1}, {9'h0, preempted});
    rv_et_n = 1'b1;
    waitv(bus_owner, 1'b1, "owner");
    ten_first = 1'b1;
    cyc(1);
    ten_first = 1'b0;
    cyc(1);
    chk("et on", 10'h0, {9'h0, et_n_oe_n});
    ten_last = 1'b1;
    cyc(1);
    ten_last = 1'b0;
    ten_req = 1'b0;
    cyc(1);
    chk("rq off", 10'h3, {8'h0, rq1_n, rq0_n});
    cyc(2);
    chk("regrant", 10'h5, {7'h0, gr_n, rv_gr_n, pe_n});
    ten_done = 1'b1;
    cyc(1);
    ten_done = 1'b0;
    cyc(2);
    chk("et off", 10'h1, {9'h0, et_n_oe_n});
    rv_rq_n = 1'b1;
    cyc(2);
    chk("no grant", 10'h3, {8'h0, gr_n, rv_gr_n});
  endtask : tenure

  task automatic send_msg(input logic cen, input logic [6:0] v,
                          input logic [5:0] sl, input logic rv);
    logic [7:0] p1, p2;
    logic       two;
    two = !central_mode || cen;
    p1 = !central_mode ? 8'hFF : cen ? {1'b0, v} : {1'b1, v};
    p2 = !central_mode ? {1'b1, v} : {2'b00, sl};
    if (!cen || !central_mode)
      exp_q.push_back({v == cbam_pkg::BP_DELAY_CODE && monarch_cap,
                       v >= cbam_pkg::PF_LO, 1'b1, v});
    if (rv) begin
      rv_ab_n = ~p1;
    end else begin
      {msg_central, msg_code, msg_prio} = {cen, v, v};
      {msg_line, msg_slot} = sl;
      msg_go = 1'b1;
      cyc(1);
      msg_go = 1'b0;
      chk("pass1", {2'h0, ~p1}, {2'h0, ab_n_oe_n});
    end
    comp_pass();
    if (two) begin
      if (rv) rv_ab_n = ~p2;
      else chk("pass2", {2'h0, ~p2}, {2'h0, ab_n_oe_n});
      comp_pass();
    end
    rv_ab_n = 8'hFF;
    chk("lines free", 10'h0FF, {2'h0, ab_n_oe_n});
  endtask : send_msg

  // mid-cycle look: the one-cycle pulse has settled by then
  always @(negedge clk_sys) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0)
        chk("rx extra", 10'h0, {rx_bp_delay, rx_power_fail, rx_cn});
      else
        chk("rx", exp_q.pop_front(),
            {rx_bp_delay, rx_power_fail, rx_cn});
    end
  end

  initial begin
    void'($urandom(32'h6D6F53D4));
    do_reset(cbam_pkg::PROF_B, 1'b0);
    chk("mode b", 10'h1, {9'h0, central_mode});
    chk("idle", 10'h3FF, {rq1_n, rq0_n, ab_n_oe_n});
    for (int l = 1; l < 4; l++) tenure(l[1:0]);
    for (int k = 0; k < 8; k++)
      send_msg(k[0], 7'($urandom), 6'($urandom), k[1]);
    send_msg(1'b0, cbam_pkg::PF_LO, 6'h00, 1'b0);
    send_msg(1'b0, cbam_pkg::BP_DELAY_CODE, 6'h00, 1'b1);
    do_reset(cbam_pkg::PROF_A, 1'b1);
    chk("mode a", 10'h0, {9'h0, central_mode});
    ten_req = 1'b1;
    cyc(8);
    ten_req = 1'b0;
    chk("no req", 10'h3, {8'h0, rq1_n, rq0_n});
    for (int k = 0; k < 4; k++) send_msg(1'b0, 7'($urandom), 6'h00, k[0]);
    do_reset(cbam_pkg::PROF_F, 1'b1);
    chk("mode f", 10'h1, {9'h0, central_mode});
    send_msg(1'b0, 7'($urandom), 6'h00, 1'b0);
    cyc(10);
    chk("queue", 10'h0, 10'(exp_q.size()));
    tally_and_finish();
  end
endmodule : tb
